/* File: rtl/strap_pin_mux.sv */
/*
 Strap latch and programmable function pin mux for a four-port hub.
 Assumes strap levels are sensed upstream and synchronous to mclk;
 the peripheral side supplies function outputs and enables.
*/
// How it works
// - Straps are sampled once as power-on or chip reset releases.
// - Sampled D+ disable strap 0 enables; 1 disables only with D- also 1, per port.
// - Sampled D- disable strap 0 enables; 1 disables only with D+ also 1, per port.
// - A port is disabled only when both its disable straps are high.
// - A disabled port also loses its SuperSpeed path.
// - Fixed-device strap level gives zero to four non-removable ports.
// - Charging strap level gives zero to four charging ports.
// - Thirty pins 2 to 31 default to one of four sets.
// - Select strap 1 level picks set; other combinations are reserved.
// - Set 3 puts serial port signals on pins 2-7, 28.
// - Set 2 puts audio signals on pins 3-7 and detect on 27.
// - Set 1 has general I/O on 2-7, alerts on 27, 28.
// - Set 4 has general I/O on 2-7, 19, 26, 27, 28.
// - Sets 1-3 put target two-wire data on 19, clock on 26.
// - Pins 8-18 carry Type-C, power and mux controls always.
// - Pins 20-25 carry the serial flash always.
// - Pin 29 general I/O, pins 30, 31 controller two-wire always.
// - Pin map registers can be overwritten after defaults load.
`timescale 1ns/100ps
module strap_pin_mux
   import strap_mux_pkg::*;
(
   // Clock and resets
   input wire logic mclk,
   input wire logic srst,
   input wire logic chip_reset_n,
   // Straps
   input wire logic [4:1] port_dplus_disable_strap,
   input wire logic [4:1] port_dminus_disable_strap,
   input wire logic [2:0] fixed_device_ports_strap,
   input wire logic [2:0] charging_ports_strap,
   input wire logic [2:0] pin_set_strap1,
   input wire logic [2:0] pin_set_strap2,
   input wire logic [2:0] pin_set_strap3,
   // Decoded settings
   output logic straps_valid,
   output logic [4:1] port_disable,
   output logic [4:1] port_ss_disable,
   output logic [4:1] fixed_ports,
   output logic [4:1] charging_ports,
   output pin_set_t pin_set,
   output logic pin_set_reserved,
   // Pin map override
   input wire logic map_we,
   input wire logic [4:0] map_pin,
   input wire fn_t map_func,
   // Peripheral side
   input wire logic [NFN-1:0] func_out,
   input wire logic [NFN-1:0] func_oe,
   output logic [NFN-1:0] func_in,
   // Programmable function pins
   input wire logic [PIN_HI:PIN_LO] pin_in,
   output logic [PIN_HI:PIN_LO] pin_out,
   output logic [PIN_HI:PIN_LO] pin_oe_n
);

   logic in_reset;
   logic in_reset_r;
   logic sample;
   logic [3:0] fixed_mask;
   logic fixed_known;
   logic [3:0] chg_mask;
   logic chg_known;
   logic [2:0] sel_cnt;
   logic sel_known;
   logic sel_ok;
   pin_set_t set_nxt;
   logic [4:1] dis_nxt;
   logic map_hit;
   fn_t map_r [PIN_HI:PIN_LO];
   logic [PIN_HI:PIN_LO] pin_out_nxt;
   logic [PIN_HI:PIN_LO] pin_oe_n_nxt;
   logic [NFN-1:0] func_in_nxt;

   // Default function of a pin in a given set
   function automatic fn_t default_fn(input pin_set_t s, input int p);
      fn_t f;
      logic aud;
      logic ser;
      logic gp;
      f = f_none;
      aud = (s == set_audio);
      ser = (s == set_serial);
      gp = (s == set_gpio);
      case (p)
         2: f = ser ? f_serial_clear_to_send_n : f_general_io_66;
         3: f = aud ? f_audio_data_in : ser ? f_serial_request_to_send_n
               : f_general_io_67;
         4: f = aud ? f_audio_data_out : ser ? f_serial_set_ready_n
               : f_general_io_68;
         5: f = aud ? f_audio_bit_clock : ser ? f_serial_terminal_ready_n
               : f_general_io_69;
         6: f = aud ? f_audio_word_clock : ser ? f_serial_receive
               : f_general_io_70;
         7: f = aud ? f_audio_master_clock : ser ? f_serial_transmit
               : f_general_io_71;
         8: f = f_plug_orientation_port1;
         9: f = f_attach_indication_port1;
         10: f = f_plug_orientation_port2;
         11: f = f_attach_indication_port2;
         12: f = f_port3_superspeed_power_control;
         13: f = f_port3_power_control;
         14: f = f_connector_polarity;
         15: f = f_port2_power_control;
         16: f = f_port4_power_control;
         17: f = f_port1_power_control;
         18: f = f_alternate_mode_mux_enable;
         19: f = gp ? f_general_io_83 : f_target_twowire_data;
         20: f = f_flash_select_n;
         21: f = f_flash_clock;
         22: f = f_flash_data_line0;
         23: f = f_flash_data_line1;
         24: f = f_flash_data_line2;
         25: f = f_flash_data_line3;
         26: f = gp ? f_general_io_90 : f_target_twowire_clock;
         27: begin
            case (s)
               set_twowire: f = f_port1_alert_in;
               set_audio: f = f_microphone_detect;
               default: f = f_general_io_91;
            endcase
         end
         28: begin
            case (s)
               set_twowire: f = f_port2_alert_in;
               set_serial: f = f_serial_carrier_detect_n;
               default: f = f_general_io_92;
            endcase
         end
         29: f = f_general_io_93;
         30: f = f_controller_twowire_clock;
         31: f = f_controller_twowire_data;
         default: f = f_none;
      endcase
      return f;
   endfunction

   // Reset release detection
   assign in_reset = srst | ~chip_reset_n;
   assign sample = in_reset_r & ~in_reset;

   strap_level_decode u_fixed (
      .level(fixed_device_ports_strap),
      .count(),
      .mask(fixed_mask),
      .known(fixed_known)
   );

   strap_level_decode u_chg (
      .level(charging_ports_strap),
      .count(),
      .mask(chg_mask),
      .known(chg_known)
   );

   strap_level_decode u_sel (
      .level(pin_set_strap1),
      .count(sel_cnt),
      .mask(),
      .known(sel_known)
   );

   // Third select strap deliberately unread
   assign sel_ok = sel_known & (sel_cnt < 3'h4) & (pin_set_strap2 == LVL_WEAK_DOWN);
   assign set_nxt = sel_ok ? pin_set_t'(sel_cnt[1:0]) : set_twowire;
   assign dis_nxt = port_dplus_disable_strap & port_dminus_disable_strap;

   assign map_hit = map_we & ~in_reset & (map_pin >= 5'(PIN_LO));

   always_ff @(posedge mclk) begin
      if (srst) begin
         in_reset_r <= 1'b1;
      end else begin
         in_reset_r <= in_reset;
      end
   end

   // Strap latch; held between samples
   always_ff @(posedge mclk) begin
      if (srst) begin
         straps_valid <= 1'b0;
         port_disable <= PORT_MASK_RST;
         port_ss_disable <= PORT_MASK_RST;
         fixed_ports <= PORT_MASK_RST;
         charging_ports <= PORT_MASK_RST;
         pin_set <= set_twowire;
         pin_set_reserved <= 1'b0;
      end else if (sample) begin
         straps_valid <= 1'b1;
         port_disable <= dis_nxt;
         port_ss_disable <= dis_nxt;
         fixed_ports <= fixed_known ? fixed_mask : PORT_MASK_RST;
         charging_ports <= chg_known ? chg_mask : PORT_MASK_RST;
         pin_set <= set_nxt;
         pin_set_reserved <= ~sel_ok;
      end
   end

   // Pin map: defaults on sample, then overrides
   always_ff @(posedge mclk) begin
      if (srst) begin
         for (int p = PIN_LO; p <= PIN_HI; p++) begin
            map_r[p] <= f_none;
         end
      end else if (sample) begin
         for (int p = PIN_LO; p <= PIN_HI; p++) begin
            map_r[p] <= default_fn(set_nxt, p);
         end
      end else if (map_hit) begin
         map_r[map_pin] <= map_func;
      end
   end

   // Pin selection from the map
   for (genvar p = PIN_LO; p <= PIN_HI; p++) begin : g_pin
      assign pin_out_nxt[p] = func_out[map_r[p]];
      assign pin_oe_n_nxt[p] = ~(func_oe[map_r[p]] & (map_r[p] != f_none));
   end

   // Inputs back to functions; unmapped functions read low
   always_comb begin
      func_in_nxt = '0;
      for (int p = PIN_LO; p <= PIN_HI; p++) begin
         func_in_nxt[map_r[p]] = func_in_nxt[map_r[p]] | pin_in[p];
      end
      func_in_nxt[f_none] = 1'b0;
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         pin_out <= PIN_OUT_RST;
         pin_oe_n <= PIN_OE_N_RST;
         func_in <= '0;
      end else begin
         pin_out <= pin_out_nxt;
         pin_oe_n <= pin_oe_n_nxt;
         func_in <= func_in_nxt;
      end
   end

   // Checks
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (srst);

   a_strap_hold: assert property (
      !sample |=> $stable(port_disable) && $stable(fixed_ports) && $stable(pin_set))
      else $error("strap setting changed without a reset release");

   a_port_disable: assert property (
      sample |=> port_disable == ($past(port_dplus_disable_strap)
         & $past(port_dminus_disable_strap)))
      else $error("port disable does not match both disable straps");

   a_ss_follow: assert property (
      straps_valid |-> port_ss_disable == port_disable)
      else $error("superspeed disable differs from port disable");

   a_fixed_all: assert property (
      sample && fixed_device_ports_strap == LVL_SHORT_DOWN |=> fixed_ports == 4'hf)
      else $error("near-short strap did not fix all ports");

   a_charge_off: assert property (
      sample && charging_ports_strap == LVL_WEAK_DOWN |=> charging_ports == 4'h0)
      else $error("weak pull-down strap left charging on");

   a_set_serial: assert property (
      sample && pin_set_strap1 == LVL_STRONG_DOWN && pin_set_strap2 == LVL_WEAK_DOWN
      |=> pin_set == set_serial && !pin_set_reserved)
      else $error("select straps did not pick the serial set");

   a_serial_pins: assert property (
      sample && set_nxt == set_serial
      |=> map_r[7] == f_serial_transmit && map_r[28] == f_serial_carrier_detect_n)
      else $error("serial set pins wrong");

   a_target_pins: assert property (
      sample && set_nxt != set_gpio
      |=> map_r[19] == f_target_twowire_data && map_r[26] == f_target_twowire_clock)
      else $error("target two-wire pins wrong");

   a_flash_pins: assert property (
      sample |=> map_r[20] == f_flash_select_n && map_r[25] == f_flash_data_line3)
      else $error("flash pins wrong");

   a_fixed_pins: assert property (
      sample |=> map_r[29] == f_general_io_93 && map_r[31] == f_controller_twowire_data)
      else $error("pins 29 to 31 wrong");

   a_override: assert property (
      map_hit && !sample |=> map_r[$past(map_pin)] == $past(map_func))
      else $error("pin map override not stored");

   a_pin_route: assert property (
      !$past(srst) |-> pin_out[22] == $past(func_out[map_r[22]]))
      else $error("pin output not routed from its function");

   a_valid_sample: assert property (
      sample |=> straps_valid)
      else $error("settings not marked valid after sampling");

   a_dplus_enable: assert property (
      sample |=> (port_disable & ~$past(port_dplus_disable_strap)) == 4'h0)
      else $error("port disabled with its D+ strap low");

   a_dminus_enable: assert property (
      sample |=> (port_disable & ~$past(port_dminus_disable_strap)) == 4'h0)
      else $error("port disabled with its D- strap low");

   a_third_ignored: assert property (
      sample && pin_set_strap1 <= LVL_STRONG_UP && pin_set_strap2 == LVL_WEAK_DOWN
      |=> !pin_set_reserved)
      else $error("listed select levels flagged as reserved");

   a_audio_pins: assert property (
      sample && set_nxt == set_audio
      |=> map_r[2] == f_general_io_66 && map_r[3] == f_audio_data_in
         && map_r[27] == f_microphone_detect && map_r[28] == f_general_io_92)
      else $error("audio set pins wrong");

   a_twowire_pins: assert property (
      sample && set_nxt == set_twowire
      |=> map_r[7] == f_general_io_71 && map_r[27] == f_port1_alert_in
         && map_r[28] == f_port2_alert_in)
      else $error("two-wire set pins wrong");

   a_gpio_pins: assert property (
      sample && set_nxt == set_gpio
      |=> map_r[19] == f_general_io_83 && map_r[26] == f_general_io_90
         && map_r[27] == f_general_io_91)
      else $error("general I/O set pins wrong");

   a_common_pins: assert property (
      sample |=> map_r[8] == f_plug_orientation_port1
         && map_r[12] == f_port3_superspeed_power_control
         && map_r[14] == f_connector_polarity && map_r[18] == f_alternate_mode_mux_enable)
      else $error("fixed control pins wrong");

   c_audio_set: cover property (sample && set_nxt == set_audio);
   c_override: cover property ((map_hit && map_pin == 5'h5) ##3 pin_oe_n[5] == 1'b0);
   c_port_off: cover property (sample ##1 port_disable[4]);
   c_gpio_set: cover property (sample && set_nxt == set_gpio);
   c_reserved: cover property (sample ##1 pin_set_reserved);

endmodule

/* File: rtl/strap_mux_pkg.sv */
/*
 Constants and types for the strap latch and pin function mux.
 Assumes strap levels arrive already sensed as level codes.
*/
package strap_mux_pkg;

   // Pin numbering and port count
   localparam int PIN_LO = 2;
   localparam int PIN_HI = 31;
   localparam int NPIN = 30;
   localparam int NPORT = 4;

   // Sensed strap level codes
   localparam logic [2:0] LVL_WEAK_DOWN = 3'h0;
   localparam logic [2:0] LVL_WEAK_UP = 3'h1;
   localparam logic [2:0] LVL_STRONG_DOWN = 3'h2;
   localparam logic [2:0] LVL_STRONG_UP = 3'h3;
   localparam logic [2:0] LVL_SHORT_DOWN = 3'h4;

   // Reset values
   localparam logic [3:0] PORT_MASK_RST = 4'h0;
   localparam logic [29:0] PIN_OUT_RST = 30'h0;
   localparam logic [29:0] PIN_OE_N_RST = 30'h3fffffff;

   typedef enum logic [1:0] {
      set_twowire, set_audio, set_serial, set_gpio
   } pin_set_t;

   typedef enum logic [5:0] {
      f_none,
      f_general_io_66, f_general_io_67, f_general_io_68,
      f_general_io_69, f_general_io_70, f_general_io_71,
      f_general_io_83, f_general_io_90, f_general_io_91,
      f_general_io_92, f_general_io_93,
      f_serial_clear_to_send_n, f_serial_request_to_send_n,
      f_serial_set_ready_n, f_serial_terminal_ready_n,
      f_serial_receive, f_serial_transmit, f_serial_carrier_detect_n,
      f_audio_data_in, f_audio_data_out, f_audio_bit_clock,
      f_audio_word_clock, f_audio_master_clock, f_microphone_detect,
      f_port1_alert_in, f_port2_alert_in,
      f_plug_orientation_port1, f_attach_indication_port1,
      f_plug_orientation_port2, f_attach_indication_port2,
      f_port3_superspeed_power_control, f_port3_power_control,
      f_connector_polarity, f_port2_power_control,
      f_port4_power_control, f_port1_power_control,
      f_alternate_mode_mux_enable, f_target_twowire_data,
      f_flash_select_n, f_flash_clock, f_flash_data_line0,
      f_flash_data_line1, f_flash_data_line2, f_flash_data_line3,
      f_target_twowire_clock, f_controller_twowire_clock,
      f_controller_twowire_data
   } fn_t;

   localparam int NFN = 48;

endpackage

/* File: rtl/strap_level_decode.sv */
/*
 Five-level strap decoder: level code to port count and port mask.
 Assumes the level code is held stable by the caller while sampled.
*/
`timescale 1ns/100ps
module strap_level_decode
   import strap_mux_pkg::*;
(
   // Sensed level
   input wire logic [2:0] level,
   // Decoded setting
   output logic [2:0] count,
   output logic [3:0] mask,
   output logic known
);

   always_comb begin
      count = 3'h0;
      mask = 4'h0;
      known = 1'b1;
      case (level)
         LVL_WEAK_DOWN: begin
            count = 3'h0;
            mask = 4'h0;
         end
         LVL_WEAK_UP: begin
            count = 3'h1;
            mask = 4'h1;
         end
         LVL_STRONG_DOWN: begin
            count = 3'h2;
            mask = 4'h3;
         end
         LVL_STRONG_UP: begin
            count = 3'h3;
            mask = 4'h7;
         end
         LVL_SHORT_DOWN: begin
            count = 3'h4;
            mask = 4'hf;
         end
         default: begin
            known = 1'b0;
         end
      endcase
   end

endmodule

/* File: dv/strap_board.sv */
/*
 Board model: strap resistors and the external chip reset source.
 Assumes the bench changes its wanted wiring at the falling clock edge.
*/
`timescale 1ns/100ps
module strap_board
   import strap_mux_pkg::*;
(
   // Wanted board wiring
   input wire logic [4:1] want_dp,
   input wire logic [4:1] want_dm,
   input wire logic [2:0] want_fix,
   input wire logic [2:0] want_chg,
   input wire logic [2:0] want_sel1,
   input wire logic [2:0] want_sel2,
   input wire logic [2:0] bad_sel3,
   input wire logic miswire,
   input wire logic reset_req,
   // Strap lines and reset
   output logic [4:1] dp_strap,
   output logic [4:1] dm_strap,
   output logic [2:0] fix_strap,
   output logic [2:0] chg_strap,
   output logic [2:0] sel1_strap,
   output logic [2:0] sel2_strap,
   output logic [2:0] sel3_strap,
   output logic chip_reset_n
);
   // Both lines pulled high for a port to be disabled
   assign dp_strap = want_dp;
   assign dm_strap = want_dm;
   assign fix_strap = want_fix;
   assign chg_strap = want_chg;
   // Select straps 1 and 2 as wanted; strap 3 weak pull-down unless miswired
   assign sel1_strap = want_sel1;
   assign sel2_strap = want_sel2;
   assign sel3_strap = miswire ? bad_sel3 : LVL_WEAK_DOWN;
   assign chip_reset_n = !reset_req;
endmodule

/* File: dv/strap_pin_mux_tb.sv */
/*
 Self-checking bench for the strap latch and pin function mux.
 Assumes the board model in strap_board.sv and the package constants.
*/
`timescale 1ns/100ps
module strap_pin_mux_tb;
   import strap_mux_pkg::*;
   typedef struct {
      logic [2:0] fx, cg, s1;
      logic [3:0] dp, dm, dis, efx, ecg;
      logic [1:0] eset;
   } row_t;
   logic mclk = 1'b0, srst = 1'b1, reset_req = 1'b0, miswire = 1'b0, map_we = 1'b0;
   logic [4:1] want_dp = 4'h0, want_dm = 4'h0, dps, dms, pdis, pss, fixp, chgp;
   logic [2:0] want_fix = 3'h0, want_chg = 3'h0, want_sel1 = 3'h0, want_sel2 = 3'h0;
   logic [2:0] bad_sel3 = 3'h3, fxs, cgs, s1s, s2s, s3s;
   logic chip_reset_n, straps_valid, rsvd;
   pin_set_t pin_set;
   logic [4:0] map_pin = 5'h0;
   fn_t map_func = f_none;
   logic [NFN-1:0] func_out = '0, func_oe = '0, func_in;
   logic [31:2] pin_in = '0, pin_out, pin_oe_n;
   int fails = 0, check_count = 0;
   row_t rows [5] = '{
      '{3'h0, 3'h4, 3'h0, 4'h5, 4'h3, 4'h1, 4'h0, 4'hf, 2'h0},
      '{3'h1, 3'h3, 3'h1, 4'hf, 4'h0, 4'h0, 4'h1, 4'h7, 2'h1},
      '{3'h2, 3'h2, 3'h2, 4'ha, 4'he, 4'ha, 4'h3, 4'h3, 2'h2},
      '{3'h3, 3'h1, 3'h3, 4'hf, 4'hf, 4'hf, 4'h7, 4'h1, 2'h3},
      '{3'h4, 3'h0, 3'h0, 4'h0, 4'hf, 4'h0, 4'hf, 4'h0, 2'h0}};

   always #20 mclk = ~mclk;

   strap_board board (.want_dp(want_dp), .want_dm(want_dm), .want_fix(want_fix),
      .want_chg(want_chg), .want_sel1(want_sel1), .want_sel2(want_sel2),
      .bad_sel3(bad_sel3), .miswire(miswire), .reset_req(reset_req), .dp_strap(dps),
      .dm_strap(dms), .fix_strap(fxs), .chg_strap(cgs), .sel1_strap(s1s),
      .sel2_strap(s2s), .sel3_strap(s3s), .chip_reset_n(chip_reset_n));

   strap_pin_mux dut (.mclk(mclk), .srst(srst), .chip_reset_n(chip_reset_n),
      .port_dplus_disable_strap(dps), .port_dminus_disable_strap(dms),
      .fixed_device_ports_strap(fxs), .charging_ports_strap(cgs), .pin_set_strap1(s1s),
      .pin_set_strap2(s2s), .pin_set_strap3(s3s), .straps_valid(straps_valid),
      .port_disable(pdis), .port_ss_disable(pss), .fixed_ports(fixp),
      .charging_ports(chgp), .pin_set(pin_set), .pin_set_reserved(rsvd),
      .map_we(map_we), .map_pin(map_pin), .map_func(map_func), .func_out(func_out),
      .func_oe(func_oe), .func_in(func_in), .pin_in(pin_in), .pin_out(pin_out),
      .pin_oe_n(pin_oe_n));

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic end_of_test;
      $display("checks=%0d fails=%0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // Default function of a pin for a select set
   function automatic fn_t exp_fn(input int p, input int s);
      if (p >= 8 && p <= 26 && !(s == 3 && (p == 19 || p == 26)))
         return fn_t'(int'(f_plug_orientation_port1) + p - 8);
      if (p <= 7) begin
         if (s == 2)
            return fn_t'(int'(f_serial_clear_to_send_n) + p - 2);
         if (s == 1 && p > 2)
            return fn_t'(int'(f_audio_data_in) + p - 3);
         return fn_t'(int'(f_general_io_66) + p - 2);
      end
      case (p)
         19: return f_general_io_83;
         26: return f_general_io_90;
         27: return s == 0 ? f_port1_alert_in : s == 1 ? f_microphone_detect : f_general_io_91;
         28: return s == 0 ? f_port2_alert_in : s == 2 ? f_serial_carrier_detect_n :
            f_general_io_92;
         29: return f_general_io_93;
         30: return f_controller_twowire_clock;
         default: return f_controller_twowire_data;
      endcase
   endfunction

   // Straps already set; pulse one reset source and let it settle
   task automatic pulse(input logic chip);
      @(negedge mclk);
      if (chip) reset_req = 1'b1;
      else srst = 1'b1;
      @(negedge mclk);
      reset_req = 1'b0;
      srst = 1'b0;
      repeat (2) @(negedge mclk);
   endtask

   // One-hot traffic through a single pin in both directions
   task automatic walk(input int p, input int s);
      fn_t e;
      e = exp_fn(p, s);
      func_out = 48'h1 << e;
      func_oe = 48'h1 << e;
      pin_in = 30'h1 << (p - 2);
      @(negedge mclk);
      check(pin_out, 30'h1 << (p - 2));
      check(pin_oe_n, 30'(~(30'h1 << (p - 2))));
      check(func_in, 48'h1 << e);
   endtask

   initial begin
      repeat (10) @(negedge mclk);
      check(straps_valid, 1'b0);
      check(pin_oe_n, 30'h3fffffff);
      for (int i = 0; i < 5; i++) begin
         want_fix = rows[i].fx;
         want_chg = rows[i].cg;
         want_sel1 = rows[i].s1;
         want_dp = rows[i].dp;
         want_dm = rows[i].dm;
         pulse(i[0]);
         check(straps_valid, 1'b1);
         check(pdis, rows[i].dis);
         check(pss, rows[i].dis);
         check(fixp, rows[i].efx);
         check(chgp, rows[i].ecg);
         check(pin_set, rows[i].eset);
         check(rsvd, 1'b0);
         for (int p = 2; p < 32; p++)
            walk(p, rows[i].eset);
      end
      // Strap changes outside reset have no effect
      want_fix = 3'h0;
      want_dp = 4'hf;
      repeat (3) @(negedge mclk);
      check(fixp, 4'hf);
      check(pdis, 4'h0);
      // Reserved select combination
      want_sel2 = LVL_WEAK_UP;
      want_sel1 = LVL_STRONG_DOWN;
      want_chg = LVL_SHORT_DOWN;
      pulse(1'b0);
      check(chgp, 4'hf);
      check(rsvd, 1'b1);
      check(pin_set, set_twowire);
      check(pss, 4'hf);
      // Third select strap miswired high
      want_sel2 = LVL_WEAK_DOWN;
      miswire = 1'b1;
      want_chg = 3'h7;
      pulse(1'b1);
      check(chgp, 4'h0);
      check(pin_set, set_serial);
      check(rsvd, 1'b0);
      // Override back to back, pin 1 refused
      map_we = 1'b1;
      map_pin = 5'h5;
      map_func = f_general_io_93;
      @(negedge mclk);
      map_pin = 5'h1;
      map_func = f_general_io_66;
      @(negedge mclk);
      map_we = 1'b0;
      func_out = 48'h1 << f_general_io_93;
      func_oe = 48'h1 << f_general_io_93;
      pin_in = '0;
      @(negedge mclk);
      check(pin_out, 30'h08000008);
      pulse(1'b0);
      walk(5, 2);
      end_of_test;
   end

   initial begin
      repeat (5000) @(posedge mclk);
      fails++;
      end_of_test;
   end
endmodule
